/* File: cond_flags_consts.svh */
// Purpose: shared constants for the condition flag and alignment block
// Assumes: 32-bit datapath
// Notes:   condition codes use the usual 4-bit encoding order
`ifndef COND_FLAGS_CONSTS_SVH
`define COND_FLAGS_CONSTS_SVH

// ----------------------------------------------------------------
// condition codes
// ----------------------------------------------------------------
`define CC_ZERO_SET        4'h0
`define CC_ZERO_CLEAR      4'h1
`define CC_CARRY_SET       4'h2
`define CC_CARRY_CLEAR     4'h3
`define CC_NEGATIVE        4'h4
`define CC_POSITIVE        4'h5
`define CC_OVERFLOW_SET    4'h6
`define CC_OVERFLOW_CLEAR  4'h7
`define CC_UNSIGNED_ABOVE  4'h8
`define CC_UNSIGNED_BELEQ  4'h9
`define CC_SIGNED_NOTLESS  4'ha
`define CC_SIGNED_LESS     4'hb
`define CC_SIGNED_GREATER  4'hc
`define CC_SIGNED_NOTGRTR  4'hd
`define CC_EVERY_TIME      4'he

// ----------------------------------------------------------------
// flag positions inside the status word and reset value
// ----------------------------------------------------------------
`define FLAG_N_POS         3
`define FLAG_Z_POS         2
`define FLAG_C_POS         1
`define FLAG_V_POS         0
`define FLAGS_RESET        4'h0

// ----------------------------------------------------------------
// pc offset for label resolution
// ----------------------------------------------------------------
`define PC_LABEL_OFFSET    32'h0000_0004

`endif

/* File: cond_flags_pkg.sv */
// Purpose: types for the condition flag and alignment block
// Assumes: nothing beyond the constants header
// Notes:   operation and access classes are enums
package cond_flags_pkg;

    // ----------------------------------------------------------------
    // alu operation class
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        op_add,
        op_sub,
        op_compare_by_add,
        op_compare_by_subtract,
        op_logical,
        op_move
    } alu_op_e;

    // ----------------------------------------------------------------
    // memory access class
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        acc_byte,
        acc_half,
        acc_word,
        acc_dual_word,
        acc_multi_word
    } acc_size_e;

    // ----------------------------------------------------------------
    // pc formation for labels
    // ----------------------------------------------------------------
    typedef enum logic [0:0]
    {
        pc_branch_style,
        pc_word_aligned
    } pc_mode_e;

endpackage

/* File: cond_eval.sv */
// Purpose: evaluate a condition code against the flags
// Assumes: flags packed as n z c v
// Notes:   purely combinational
`timescale 1ns/10ps
`include "cond_flags_consts.svh"
module cond_eval
(
    input  wire logic [3:0] cond,
    input  wire logic [3:0] flags,
    output logic            pass
);

    // ----------------------------------------------------------------
    // flag split
    // ----------------------------------------------------------------
    wire n = flags[`FLAG_N_POS];
    wire z = flags[`FLAG_Z_POS];
    wire c = flags[`FLAG_C_POS];
    wire v = flags[`FLAG_V_POS];

    // condition table
    always_comb
    begin
        case (cond)
            `CC_ZERO_SET:       pass = z;
            `CC_ZERO_CLEAR:     pass = !z;
            `CC_CARRY_SET:      pass = c;
            `CC_CARRY_CLEAR:    pass = !c;
            `CC_NEGATIVE:       pass = n;
            `CC_POSITIVE:       pass = !n;
            `CC_OVERFLOW_SET:   pass = v;
            `CC_OVERFLOW_CLEAR: pass = !v;
            `CC_UNSIGNED_ABOVE: pass = c && !z;
            `CC_UNSIGNED_BELEQ: pass = !c || z;
            `CC_SIGNED_NOTLESS: pass = (n == v);
            `CC_SIGNED_LESS:    pass = (n != v);
            `CC_SIGNED_GREATER: pass = !z && (n == v);
            `CC_SIGNED_NOTGRTR: pass = z || (n != v);
            default:            pass = 1'b1;
        endcase
    end

endmodule

/* File: align_check.sv */
// Purpose: alignment check and misaligned fault decision
// Assumes: size class and unaligned-capable flag come from decode
// Notes:   purely combinational
`timescale 1ns/10ps
module align_check
    import cond_flags_pkg::*;
(
    input  wire logic [1:0] addr_low,
    input  acc_size_e       size,
    input  wire logic       single_ok,
    input  wire logic       trap_enable,
    output logic            misaligned,
    output logic            fault
);

    // ----------------------------------------------------------------
    // alignment classes
    // ----------------------------------------------------------------
    // byte always aligned
    wire word_class = (size == acc_word) || (size == acc_dual_word)
                   || (size == acc_multi_word);
    assign misaligned = (word_class && (addr_low != 2'h0))
                     || ((size == acc_half) && addr_low[0]);

    // only single word and half may be unaligned
    wire allowed = single_ok && ((size == acc_word) || (size == acc_half));
    // others fault; trap bit faults all
    assign fault = misaligned && (!allowed || trap_enable);

endmodule

/* File: cond_flags_align_check.sv */
// Purpose: flag generation, conditional execution, alignment, label pc
// Assumes: one instruction presented per cycle with instr_valid
// Notes:   all outputs are registered, one cycle after the request
`timescale 1ns/10ps
`include "cond_flags_consts.svh"

// How it works
// - word class aligned on word addresses, half on half, bytes always.
// - only single word and halfword loads and stores may be unaligned.
// - other unaligned loads or stores raise the misuse fault instead.
// - trap enable makes every unaligned access fault.
// - branches and compare-branches use instruction address plus four.
// - other label users use address plus four with bit one cleared.
// - flags not updated by an instruction keep their old value.
// - failed condition means no write, no flag change, no fault.
// - flags persist until some later instruction updates them.
// - negative and zero flags follow the result, cleared otherwise.
// - carry from add overflow past 32 bits, no-borrow, or shifter.
// - overflow when result sign differs from infinite precision sign.
// - compares set flags like add or subtract but write nothing.
// - flags change only on a compare or when the flag-setting variant is used.
// - single-flag conditions test one flag set or clear.
// - above is carry and not zero; below-equal is its complement.
// - not-less is n equals v, less differs, greater adds not-zero.
// - every-time condition passes; it is the default.
// - short and long encodings execute the same operation.
module cond_flags_align_check
    import cond_flags_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        instr_valid,
    input  wire logic        instr_wide,
    input  wire logic [31:0] instr_addr,
    input  wire logic [3:0]  cond,
    input  wire logic        has_cond,
    input  alu_op_e          op,
    input  wire logic        set_flags,
    input  wire logic        upd_nz,
    input  wire logic        upd_c,
    input  wire logic        upd_v,
    input  wire logic [31:0] operand_a,
    input  wire logic [31:0] operand_b,
    input  wire logic        shifter_carry,
    input  wire logic        shifter_carry_valid,
    input  wire logic        wants_dest,
    input  wire logic        is_mem,
    input  acc_size_e        mem_size,
    input  wire logic        mem_single_ok,
    input  wire logic [31:0] mem_addr,
    input  pc_mode_e         pc_mode,
    input  wire logic        misaligned_trap_enable,
    output logic [3:0]       app_status_flags_word,
    output logic [31:0]      result,
    output logic             result_write,
    output logic             executed,
    output logic             misaligned_access,
    output logic             misuse_fault_exception,
    output logic [31:0]      label_pc,
    output logic             out_valid
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0]  flags_q;
    logic [3:0]  flags_d;
    logic [31:0] result_q;
    logic        result_write_q;
    logic        executed_q;
    logic        misaligned_q;
    logic        fault_q;
    logic [31:0] label_pc_q;
    logic        valid_q;

    // ----------------------------------------------------------------
    // condition test
    // ----------------------------------------------------------------
    logic       cond_pass;
    wire  [3:0] eff_cond = has_cond ? cond : `CC_EVERY_TIME;

    cond_eval u_cond
    (
        .cond  (eff_cond),
        .flags (flags_q),
        .pass  (cond_pass)
    );

    // width flag does not alter the operation
    wire run = instr_valid && cond_pass;

    // ----------------------------------------------------------------
    // arithmetic
    // ----------------------------------------------------------------
    // subtraction as a plus not b plus one, so carry means no borrow
    wire is_sub = (op == op_sub) || (op == op_compare_by_subtract);
    wire is_arith = (op == op_add) || (op == op_sub)
                 || (op == op_compare_by_add)
                 || (op == op_compare_by_subtract);
    wire [31:0] b_eff = is_sub ? ~operand_b : operand_b;
    // carry out of a 33-bit sum
    wire [32:0] sum = {1'b0, operand_a} + {1'b0, b_eff}
                    + {32'h0, is_sub};
    wire [31:0] logic_res = (op == op_move) ? operand_b
                          : (operand_a & operand_b);
    wire [31:0] alu_res = is_arith ? sum[31:0] : logic_res;

    // negative and zero from the result
    wire new_n = alu_res[31];
    wire new_z = (alu_res == 32'h0);
    wire new_c = is_arith ? sum[32] : shifter_carry;
    wire new_v = (operand_a[31] == b_eff[31])
              && (sum[31] != operand_a[31]);

    // ----------------------------------------------------------------
    // flag update enables
    // ----------------------------------------------------------------
    // compares always set flags
    wire is_cmp = (op == op_compare_by_add)
               || (op == op_compare_by_subtract);
    wire fl_en = run && (set_flags || is_cmp);
    // logic carry only when the shifter produced one
    wire c_en = fl_en && upd_c && (is_arith || shifter_carry_valid);
    wire v_en = fl_en && upd_v && is_arith;

    always_comb
    begin
        flags_d = flags_q;
        if (fl_en && upd_nz)
        begin
            flags_d[`FLAG_N_POS] = new_n;
            flags_d[`FLAG_Z_POS] = new_z;
        end
        if (c_en)
        begin
            flags_d[`FLAG_C_POS] = new_c;
        end
        if (v_en)
        begin
            flags_d[`FLAG_V_POS] = new_v;
        end
    end

    // ----------------------------------------------------------------
    // alignment
    // ----------------------------------------------------------------
    logic mis;
    logic flt;

    align_check u_align
    (
        .addr_low    (mem_addr[1:0]),
        .size        (mem_size),
        .single_ok   (mem_single_ok),
        .trap_enable (misaligned_trap_enable),
        .misaligned  (mis),
        .fault       (flt)
    );

    // a failed test raises no fault
    wire fault_now = run && is_mem && flt;

    wire write_now = run && wants_dest && !is_cmp && !fault_now;

    // ----------------------------------------------------------------
    // label pc
    // ----------------------------------------------------------------
    // branch style is address plus four
    wire [31:0] pc_plus4 = instr_addr + `PC_LABEL_OFFSET;
    // clear bit one for word alignment
    wire [31:0] pc_label = (pc_mode == pc_word_aligned)
                         ? {pc_plus4[31:2], 1'b0, pc_plus4[0]}
                         : pc_plus4;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // flag word, reset clear
    always_ff @(posedge clk)
    begin
        if (rst)
            flags_q <= `FLAGS_RESET;
        else
            flags_q <= flags_d;
    end

    // per-instruction results, valid one cycle after the request
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            result_q       <= 32'h0;
            result_write_q <= 1'b0;
            executed_q     <= 1'b0;
            misaligned_q   <= 1'b0;
            fault_q        <= 1'b0;
            label_pc_q     <= 32'h0;
            valid_q        <= 1'b0;
        end
        else
        begin
            result_q       <= alu_res;
            result_write_q <= write_now;
            executed_q     <= run;
            misaligned_q   <= instr_valid && is_mem && mis;
            fault_q        <= fault_now;
            label_pc_q     <= pc_label;
            valid_q        <= instr_valid;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign app_status_flags_word  = flags_q;
    assign result                 = result_q;
    assign result_write           = result_write_q;
    assign executed               = executed_q;
    assign misaligned_access      = misaligned_q;
    assign misuse_fault_exception = fault_q;
    assign label_pc               = label_pc_q;
    assign out_valid              = valid_q;

endmodule

/* File: cond_flags_align_check_sva.sv */
// Purpose: checker on the ports of the flag and alignment block
// Assumes: one clock, outputs one cycle after the request
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/10ps
`include "cond_flags_consts.svh"
module cond_flags_align_check_sva
    import cond_flags_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        instr_valid,
    input wire logic [31:0] instr_addr,
    input wire logic [3:0]  cond,
    input wire logic        has_cond,
    input alu_op_e          op,
    input wire logic        set_flags,
    input wire logic        upd_nz,
    input wire logic [31:0] operand_a,
    input wire logic [31:0] operand_b,
    input wire logic        is_mem,
    input acc_size_e        mem_size,
    input wire logic [31:0] mem_addr,
    input pc_mode_e         pc_mode,
    input wire logic        misaligned_trap_enable,
    input wire logic [3:0]  app_status_flags_word,
    input wire logic        result_write,
    input wire logic        executed,
    input wire logic        misaligned_access,
    input wire logic        misuse_fault_exception,
    input wire logic [31:0] label_pc
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // helper terms
    // ----------------------------------------------------------------
    // plain: no suffix or every-time, so the test always passes
    wire logic plain = instr_valid && (!has_cond || cond == `CC_EVERY_TIME);
    wire logic mem_v = instr_valid && is_mem;
    wire logic cmp_v = op == op_compare_by_add || op == op_compare_by_subtract;
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    branch_pc_a:
        assert property (instr_valid && pc_mode == pc_branch_style |=>
            label_pc == $past(instr_addr) + 32'h4) else $error("pc bad");
    aligned_pc_a:
        assert property (instr_valid && pc_mode == pc_word_aligned |=>
            label_pc == (($past(instr_addr) + 32'h4) & 32'hffff_fffd))
            else $error("aligned pc bad");
    byte_aligned_a:
        assert property (mem_v && mem_size == acc_byte |=>
            !misaligned_access && !misuse_fault_exception)
            else $error("byte flagged");
    word_unaligned_a:
        assert property (mem_v && mem_size inside {acc_word, acc_dual_word,
            acc_multi_word} && mem_addr[1:0] != 2'h0 |=> misaligned_access)
            else $error("word not flagged");
    multi_fault_a:
        assert property (plain && is_mem && mem_addr[1:0] != 2'h0 &&
            mem_size inside {acc_dual_word, acc_multi_word} |=>
            misuse_fault_exception && !result_write) else $error("no fault");
    trap_all_a:
        assert property (plain && is_mem && misaligned_trap_enable &&
            mem_size == acc_half && mem_addr[0] |=> misuse_fault_exception)
            else $error("trap missed");
    fail_quiet_a:
        assert property (instr_valid && has_cond && cond == `CC_ZERO_SET &&
            !app_status_flags_word[`FLAG_Z_POS] |=> !executed && !result_write
            && !misuse_fault_exception && $stable(app_status_flags_word))
            else $error("failed instr acted");
    flags_hold_a:
        assert property (!instr_valid || (!set_flags && !cmp_v) |=>
            $stable(app_status_flags_word)) else $error("flags moved");
    cmp_zero_a:
        assert property (plain && op == op_compare_by_subtract && upd_nz &&
            operand_a == operand_b |=> !result_write &&
            app_status_flags_word[3:2] == 2'h1) else $error("cmp bad");
endmodule

bind cond_flags_align_check cond_flags_align_check_sva chk (.clk, .rst,
    .instr_valid, .instr_addr, .cond, .has_cond, .op, .set_flags, .upd_nz,
    .operand_a, .operand_b, .is_mem, .mem_size, .mem_addr, .pc_mode,
    .misaligned_trap_enable, .app_status_flags_word, .result_write,
    .executed, .misaligned_access, .misuse_fault_exception, .label_pc);

/* File: fault_handler_model.sv */
// Purpose: far-side fault handler, tallies misuse faults taken
// Assumes: fault is a one-cycle pulse per faulting access
// Notes:   tally clears on reset like the block itself
`timescale 1ns/10ps
module fault_handler_model
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        misuse_fault_exception,
    output logic [15:0]     fault_total
);
    // each pulse is one exception entry
    always @(posedge clk)
        fault_total <= rst ? 16'h0 : fault_total + 16'(misuse_fault_exception);
endmodule

/* File: cond_flags_align_check_tb_top.sv */
// Purpose: random self-checking bench for the flag and alignment block
// Assumes: outputs one cycle after each valid instruction, whether its condition passes or fails
// Notes:   expectations queue at drive time, compared at negedge
`timescale 1ns/10ps
module cond_flags_align_check_tb_top
    import cond_flags_pkg::*;
;
    logic        clk, rst, instr_valid, instr_wide, has_cond, set_flags;
    logic        upd_nz, upd_c, upd_v, shifter_carry, shifter_carry_valid;
    logic        wants_dest, is_mem, mem_single_ok, misaligned_trap_enable;
    logic [31:0] instr_addr, operand_a, operand_b, mem_addr, result, label_pc;
    logic [3:0]  cond, app_status_flags_word, fl;
    alu_op_e     op;
    acc_size_e   mem_size;
    pc_mode_e    pc_mode;
    logic        result_write, executed, misaligned_access, out_valid;
    logic        misuse_fault_exception;
    logic [15:0] fault_total;
    logic [72:0] exq[$];
    logic [72:0] e;
    int          num_errors, n_compared, exp_faults, cycles;

    cond_flags_align_check uut (.clk, .rst, .instr_valid, .instr_wide,
        .instr_addr, .cond, .has_cond, .op, .set_flags, .upd_nz, .upd_c,
        .upd_v, .operand_a, .operand_b, .shifter_carry, .shifter_carry_valid,
        .wants_dest, .is_mem, .mem_size, .mem_single_ok, .mem_addr, .pc_mode,
        .misaligned_trap_enable, .app_status_flags_word, .result,
        .result_write, .executed, .misaligned_access, .misuse_fault_exception,
        .label_pc, .out_valid);
    fault_handler_model partner (.clk, .rst, .misuse_fault_exception,
        .fault_total);

    always #2 clk = ~clk;

    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic cpass(logic [3:0] c, logic [3:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[2];
            3'h1: r = f[1];
            3'h2: r = f[3];
            3'h3: r = f[0];
            3'h4: r = f[1] && !f[2];
            3'h5: r = f[3] == f[0];
            3'h6: r = !f[2] && f[3] == f[0];
            default: r = 1'b1;
        endcase
        return (c[0] && c[3:1] != 3'h7) ? !r : r;
    endfunction

    // boundary values weighted in to hit carry and overflow edges
    function automatic logic [31:0] pick();
        case ($urandom_range(3))
            0: return 32'h8000_0000;
            1: return 32'hffff_ffff;
            2: return 32'($urandom_range(2));
            default: return $urandom;
        endcase
    endfunction

    task automatic drive_one(input logic trap);
        logic [32:0] s;
        logic [3:0]  f;
        logic        p, cmp, mis, flt, wr;
        instr_valid = $urandom_range(3) != 0;
        instr_wide = 1'($urandom);
        instr_addr = $urandom;
        pc_mode = pc_mode_e'($urandom_range(1));
        // conditional ones sit in an if-then block upstream
        has_cond = 1'($urandom);
        cond = 4'($urandom);
        is_mem = $urandom_range(2) == 0;
        op = is_mem ? op_add : alu_op_e'($urandom_range(5));
        cmp = op inside {op_compare_by_add, op_compare_by_subtract};
        set_flags = !is_mem && 1'($urandom);
        upd_nz = cmp || 1'($urandom);
        upd_c = cmp || 1'($urandom);
        upd_v = cmp || 1'($urandom);
        operand_a = pick();
        operand_b = pick();
        shifter_carry = 1'($urandom);
        shifter_carry_valid = 1'($urandom);
        wants_dest = 1'($urandom);
        mem_size = acc_size_e'($urandom_range(4));
        mem_addr = $urandom;
        mem_single_ok = 1'($urandom) && mem_size inside {acc_half, acc_word};
        misaligned_trap_enable = trap;
        if (!instr_valid)
            return;
        s = op == op_logical ? {1'b0, operand_a & operand_b}
          : op == op_move ? {1'b0, operand_b}
          : (op == op_add || op == op_compare_by_add)
          ? {1'b0, operand_a} + {1'b0, operand_b}
          : {1'b0, operand_a} + {1'b0, ~operand_b} + 33'h1;
        p = !has_cond || cpass(cond, fl);
        mis = is_mem && (mem_size == acc_half ? mem_addr[0]
            : mem_size != acc_byte && mem_addr[1:0] != 2'h0);
        // only single word or half may go unaligned
        flt = p && mis && !(mem_single_ok && !trap);
        wr = p && wants_dest && !flt && !cmp;
        f = fl;
        if (p && !is_mem && (set_flags || cmp))
        begin
            if (upd_nz)
                f[3:2] = {s[31], s[31:0] == 32'h0};
            if (upd_c && (op < op_logical || shifter_carry_valid))
                f[1] = op < op_logical ? s[32] : shifter_carry;
            if (upd_v && op < op_logical)
                f[0] = s[31] != operand_a[31] && ((operand_a[31] ==
                    operand_b[31]) == (op == op_add || op == op_compare_by_add));
        end
        fl = f;
        exp_faults += int'(flt);
        exq.push_back({!cmp, f, s[31:0], wr, p, mis, flt, (instr_addr + 32'h4)
            & (pc_mode == pc_word_aligned ? 32'hffff_fffd : 32'hffff_ffff)});
    endtask

    // outputs are settled by the falling edge
    always @(negedge clk)
        if (out_valid === 1'b1)
        begin
            if (exq.size() == 0)
                check(72'h1, 72'h0);
            else
            begin
                e = exq.pop_front();
                check(72'({app_status_flags_word, result_write, executed,
                    misaligned_access, misuse_fault_exception, label_pc}),
                    72'({e[71:68], e[35:0]}));
                if (e[72])
                    check(72'(result), 72'(e[67:36]));
            end
        end

    task automatic run_rand(input logic trap, input int n, input string nm);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            drive_one(trap);
        end
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        repeat (3) @(posedge clk);
        check(72'(fault_total), 72'(exp_faults));
        check(72'(exq.size()), 72'h0);
        $display("test %s done, errors %0d", nm, num_errors);
    endtask

    task automatic final_report();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard well above the roughly 3100 cycles of traffic
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            num_errors++;
            final_report();
        end
    end

    initial
    begin
        {clk, instr_valid, instr_wide, has_cond, set_flags, upd_nz} = 6'h0;
        {upd_c, upd_v, shifter_carry, shifter_carry_valid, wants_dest} = 5'h0;
        {is_mem, mem_single_ok, misaligned_trap_enable, cond, fl} = 11'h0;
        {instr_addr, operand_a, operand_b, mem_addr} = 128'h0;
        op = op_add;
        mem_size = acc_byte;
        pc_mode = pc_branch_style;
        rst = 1'b1;
        void'($urandom(79380));
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        run_rand(1'b0, 1500, "random");
        run_rand(1'b1, 800, "trap all");
        // reset in mid-run must clear the flags; raised off the edge
        #1;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        fl = 4'h0;
        exp_faults = 0;
        check(72'({app_status_flags_word, out_valid}), 72'h0);
        run_rand(1'b0, 800, "after reset");
        final_report();
    end
endmodule
